// >>> rtl/bsc_burst_clean.sv
`timescale 1ns/1ps
//Contract
// - Burst clean enable only with two or three valves after successful auto setup.
// - Four select presses then enter toggles the burst clean option.
// - Burst clean enable is also writable over the IO-Link parameter path.
// - Reset leaves option disabled; factory default restore clears it.
// - Rising seat request energises the matching solenoid valve.
// - Reaching stored energised position de-energises the valve without waiting.
// - Successful pulse gives a handshake of at least two seconds.
// - Without seat lift sensor, valve drops after stroke time; handshake follows after the margin.
// - Valve state high when healthy; codes 15, 17, 18, 28 ignored.
// - Codes 16, 19 to 22 and 31 drop valve state on all variants.
// - Codes 23 to 27, 29, 30 drop it on digital and IO-Link only.
module bsc_burst_clean
   import bsc_pkg::*;
#(
   parameter int unsigned TICK_DIV = bsc_pkg::TICK_CYC,
   parameter int unsigned HS_T     = bsc_pkg::HS_TICKS,
   parameter int unsigned ADD_T    = bsc_pkg::ADD_TICKS
) (
   // Clock and reset
   input  wire logic                 core_clk_i,
   input  wire logic                 rst_b_i,
   // Avalon-MM slave
   input  wire bsc_pkg::bsc_avl_req_t avl_req_i,
   output logic [31:0]               avl_readdata_o,
   output logic                      avl_waitrequest_o,
   // PLC requests and setup state (pins)
   input  wire bsc_pkg::bsc_seat_t   seat_req_i,
   input  wire logic                 select_btn_i,
   input  wire logic                 enter_btn_i,
   input  wire logic                 setup_ok_i,
   input  wire logic [1:0]           sv_count_i,
   input  wire logic                 seat_sensor_i,
   input  wire bsc_pkg::bsc_if_t     if_variant_i,
   // Sensed position and error codes
   input  wire bsc_pkg::bsc_seat_t   pos_reached_i,
   input  wire logic [bsc_pkg::ERR_W-1:0] errors_i,
   // Outputs
   output bsc_pkg::bsc_seat_t        sv_on_o,
   output logic                      handshake_o,
   output logic                      valve_state_o
);
   import bsc_pkg::*;

   typedef enum logic [1:0] {
      BSC_IDLE  = 2'b00,
      BSC_PULSE = 2'b01,
      BSC_TAIL  = 2'b10,
      BSC_HS    = 2'b11
   } bsc_st_t;

   localparam logic [CNT_W-1:0] HS_LAST  = CNT_W'(HS_T);
   localparam logic [CNT_W-1:0] ADD_LAST = CNT_W'(ADD_T);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: two flops, only the second one is read
   localparam int unsigned SW = 2 + 2 + 2 + 1;
   logic [SW-1:0] s1_r;
   logic [SW-1:0] s2_r;
   wire  [SW-1:0] pins = {seat_req_i, pos_reached_i, select_btn_i, enter_btn_i, seat_sensor_i};
   logic [ERR_W-1:0] e1_r;
   logic [ERR_W-1:0] e2_r;

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s1_r <= '0;
         s2_r <= '0;
         e1_r <= '0;
         e2_r <= '0;
      end else begin
         s1_r <= pins;
         s2_r <= s1_r;
         e1_r <= errors_i;
         e2_r <= e1_r;
      end
   end

   wire bsc_seat_t req_s   = s2_r[6:5];
   wire bsc_seat_t reach_s = s2_r[4:3];
   wire            sel_s   = s2_r[2];
   wire            ent_s   = s2_r[1];
   wire            lift_s  = s2_r[0];
   logic [2:0]     prev_r;
   wire            sel_rise = sel_s & ~prev_r[2];
   wire            ent_rise = ent_s & ~prev_r[1];
   wire bsc_seat_t req_rise;

   ////////////////////////////////////////////////////////////////////////////
   // Prescaler
   logic tick;

   bsc_tick #(.DIV(TICK_DIV)) u_tick (
      .core_clk_i (core_clk_i),
      .rst_b_i    (rst_b_i),
      .tick_o     (tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Option enable
   logic        en_r;
   logic [2:0]  sel_cnt_r;
   logic [CNT_W-1:0] stroke_r;
   wire         eligible = setup_ok_i & (sv_count_i >= 2'h2);
   wire         wr_hit   = avl_req_i.write & ~avl_waitrequest_o;
   wire         wr_ctrl  = wr_hit & (avl_req_i.address == REG_CTRL);
   wire         wr_strk  = wr_hit & (avl_req_i.address == REG_STROKE);
   wire         btn_tog  = ent_rise & (sel_cnt_r == SEL_COUNT);
   wire         def_req  = wr_ctrl & avl_req_i.writedata[CTRL_DEF_BIT];
   logic        en_nxt;

   always_comb begin
      en_nxt = en_r;
      if (btn_tog)
         en_nxt = ~en_r;
      if (wr_ctrl)
         en_nxt = avl_req_i.writedata[CTRL_EN_BIT];
      if (def_req)
         en_nxt = 1'b0;
      if (!eligible)
         en_nxt = 1'b0;
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         en_r      <= 1'b0;
         sel_cnt_r <= '0;
         prev_r    <= '0;
         stroke_r  <= '0;
      end else begin
         en_r      <= en_nxt;
         prev_r    <= {sel_s, ent_s, 1'b0};
         if (ent_rise)
            sel_cnt_r <= '0;
         else if (sel_rise && sel_cnt_r != SEL_MAX)
            sel_cnt_r <= sel_cnt_r + 3'h1;
         if (wr_strk)
            stroke_r <= avl_req_i.writedata[CNT_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Seat pulse sequencer
   bsc_st_t          st_r;
   bsc_st_t          st_nxt;
   logic [CNT_W-1:0] cnt_r;
   bsc_seat_t        seat_r;
   bsc_seat_t        sv_nxt;
   bsc_seat_t        req_prev_r;
   logic             use_timer_r;
   wire              seat_reach = |(reach_s & seat_r);
   wire              tail_done  = tick & (cnt_r >= stroke_r + ADD_LAST);
   wire              hs_done    = tick & (cnt_r >= HS_LAST);
   assign req_rise = req_s & ~req_prev_r;

   always_comb begin
      st_nxt = st_r;
      sv_nxt = sv_on_o;
      unique case (st_r)
         BSC_IDLE: begin
            if (en_r && req_rise != 2'b00) begin
               st_nxt = BSC_PULSE;
               sv_nxt = req_rise.upper ? 2'b10 : 2'b01;
            end
         end
         BSC_PULSE: begin
            if (!use_timer_r && seat_reach) begin
               st_nxt = BSC_HS;
               sv_nxt = 2'b00;
            end else if (use_timer_r && tick && cnt_r >= stroke_r) begin
               st_nxt = BSC_TAIL;
               sv_nxt = 2'b00;
            end
         end
         BSC_TAIL: begin
            if (tail_done)
               st_nxt = BSC_HS;
         end
         BSC_HS: begin
            if (hs_done)
               st_nxt = BSC_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_r        <= BSC_IDLE;
         sv_on_o     <= '0;
         seat_r      <= '0;
         req_prev_r  <= '0;
         cnt_r       <= '0;
         use_timer_r <= 1'b0;
         handshake_o <= 1'b0;
      end else begin
         st_r       <= st_nxt;
         sv_on_o    <= sv_nxt;
         req_prev_r <= req_s;
         if (st_r == BSC_IDLE) begin
            seat_r      <= req_rise.upper ? 2'b10 : 2'b01;
            use_timer_r <= ~lift_s;
         end
         // tick counter, restarted when pulse or handshake begins
         if (st_nxt == BSC_HS && st_r != BSC_HS)
            cnt_r <= '0;
         else if (st_r == BSC_IDLE)
            cnt_r <= '0;
         else if (tick && st_r != BSC_TAIL && st_nxt == BSC_TAIL)
            cnt_r <= cnt_r + 16'h0001;
         else if (tick)
            cnt_r <= cnt_r + 16'h0001;
         handshake_o <= (st_nxt == BSC_HS);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Valve state
   wire dig_var = (if_variant_i != BSC_IF_ASI);
   wire [ERR_W-1:0] err_mask = ERR_MASK_ALL | (dig_var ? ERR_MASK_DIG : '0);

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         valve_state_o <= 1'b1;
      end else begin
         valve_state_o <= ~|(e2_r & err_mask);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Avalon slave: one wait cycle per access so readdata is registered
   logic        busy_r;
   wire         acc = avl_req_i.read | avl_req_i.write;
   logic [31:0] rd_mux;

   always_comb begin
      unique case (avl_req_i.address)
         REG_CTRL:   rd_mux = {31'h0000_0000, en_r};
         REG_STATUS: rd_mux = {24'h00_0000, eligible, lift_s, handshake_o, valve_state_o,
                               sv_on_o, st_r};
         REG_ERRORS: rd_mux = {15'h0000, e2_r};
         REG_STROKE: rd_mux = {16'h0000, stroke_r};
         default:    rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         busy_r            <= 1'b0;
         avl_waitrequest_o <= 1'b1;
         avl_readdata_o    <= '0;
      end else begin
         busy_r            <= acc & avl_waitrequest_o & ~busy_r;
         avl_waitrequest_o <= ~(acc & avl_waitrequest_o & ~busy_r);
         if (acc && avl_waitrequest_o)
            avl_readdata_o <= rd_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   a_en_gated: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      en_r |-> $past(eligible)) else $error("enable without eligible setup");
   a_btn_toggle: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      (btn_tog && eligible && !wr_ctrl) |=> (en_r != $past(en_r))) else $error("button did not toggle");
   a_param_write: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      (wr_ctrl && eligible && !def_req) |=> (en_r == $past(avl_req_i.writedata[CTRL_EN_BIT])))
      else $error("parameter write lost");
   a_def_clear: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      def_req |=> !en_r) else $error("default restore kept enable");
   a_sv_energise: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      (st_r == BSC_IDLE && en_r && req_rise != 2'b00) |=> (sv_on_o != 2'b00))
      else $error("valve not energised");
   a_sv_release: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      (st_r == BSC_PULSE && !use_timer_r && seat_reach) |=> (sv_on_o == 2'b00 && handshake_o))
      else $error("valve not released at position");
   a_hs_length: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      $rose(handshake_o) |-> handshake_o [*8]) else $error("handshake too short");
   a_timed_end: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      (st_r == BSC_TAIL) |-> (sv_on_o == 2'b00)) else $error("valve on during tail");
   a_vs_low: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      (|(e2_r & ERR_MASK_ALL)) |=> !valve_state_o) else $error("valve state not dropped");
   a_vs_asi: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      (if_variant_i == BSC_IF_ASI && !(|(e2_r & ERR_MASK_ALL))) |=> valve_state_o)
      else $error("AS-i variant dropped on ignored code");

endmodule // bsc_burst_clean

// >>> rtl/bsc_pkg.sv
package bsc_pkg;

   // Error code numbering
   localparam int unsigned ERR_FIRST = 15;
   localparam int unsigned ERR_LAST  = 31;
   localparam int unsigned ERR_W     = 17;

   // Error masks, bit n is error code n + ERR_FIRST
   localparam logic [16:0] ERR_MASK_ALL = 17'h1_00F2;
   localparam logic [16:0] ERR_MASK_DIG = 17'h0_DF00;

   // Interface variants
   typedef enum logic [1:0] {
      BSC_IF_DIGITAL = 2'b00,
      BSC_IF_ASI     = 2'b01,
      BSC_IF_IOLINK  = 2'b10
   } bsc_if_t;

   // Timing
   localparam int unsigned CLK_HZ        = 25_000_000;
   localparam int unsigned TICK_US       = 1_000;
   localparam int unsigned HANDSHAKE_MS  = 2_000;
   localparam int unsigned MIN_REQ_MS    = 500;
   localparam int unsigned STROKE_ADD_MS = 200;
   localparam int unsigned TICK_CYC      = CLK_HZ / 1_000_000 * TICK_US;
   localparam int unsigned HS_TICKS      = HANDSHAKE_MS * 1_000 / TICK_US;
   localparam int unsigned ADD_TICKS     = STROKE_ADD_MS * 1_000 / TICK_US;
   localparam int unsigned CNT_W         = 16;

   // Button sequence
   localparam logic [2:0] SEL_COUNT     = 3'h4;
   localparam logic [2:0] SEL_MAX       = 3'h7;

   // Avalon register map
   localparam logic [3:0] REG_CTRL     = 4'h0;
   localparam logic [3:0] REG_STATUS   = 4'h4;
   localparam logic [3:0] REG_ERRORS   = 4'h8;
   localparam logic [3:0] REG_STROKE   = 4'hC;
   localparam int unsigned CTRL_EN_BIT  = 0;
   localparam int unsigned CTRL_DEF_BIT = 1;

   typedef struct packed {
      logic upper;
      logic lower;
   } bsc_seat_t;

   typedef struct packed {
      logic       read;
      logic       write;
      logic [3:0] address;
      logic [31:0] writedata;
   } bsc_avl_req_t;

endpackage : bsc_pkg

// >>> rtl/bsc_tick.sv
`timescale 1ns/1ps
module bsc_tick
   import bsc_pkg::*;
#(
   parameter int unsigned DIV = bsc_pkg::TICK_CYC
) (
   // Clock and reset
   input  wire logic core_clk_i,
   input  wire logic rst_b_i,
   // Tick
   output logic      tick_o
);
   import bsc_pkg::*;

   localparam logic [31:0] DIV_LAST = 32'(DIV - 1);
   logic [31:0] cnt_r;
   wire         wrap = (cnt_r == DIV_LAST);

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_r  <= '0;
         tick_o <= 1'b0;
      end else begin
         cnt_r  <= wrap ? '0 : cnt_r + 32'h0000_0001;
         tick_o <= wrap;
      end
   end

endmodule // bsc_tick

// >>> bench/bsc_plc_model.sv
`timescale 1ns/1ps
module bsc_plc_model
   import bsc_pkg::*;
#(
   parameter int unsigned HOLD_CYC = 1000
) (
   // Clock
   input  wire logic          core_clk_i,
   // Device side
   input  wire bsc_pkg::bsc_seat_t sv_on_i,
   output bsc_pkg::bsc_seat_t seat_req_o,
   output bsc_pkg::bsc_seat_t pos_reached_o
);
   int unsigned reach_dly = 8;
   logic        reach_en  = 1'b1;
   int unsigned cnt       = 0;

   initial begin
      seat_req_o    = '0;
      pos_reached_o = '0;
   end

   ////////////////////////////////////////////////////////////
   // request held for HOLD_CYC clock cycles
   task automatic pulse(input logic up);
      @(posedge core_clk_i);
      seat_req_o <= '{upper: up, lower: ~up};
      repeat (HOLD_CYC) @(posedge core_clk_i);
      seat_req_o <= '0;
   endtask

   ////////////////////////////////////////////////////////////
   // Stem leaves the target as soon as the valve drops, no lingering
   always @(posedge core_clk_i) begin
      cnt           <= (sv_on_i == '0) ? 0 : cnt + 1;
      pos_reached_o <= (reach_en && sv_on_i != '0 && cnt >= reach_dly) ? sv_on_i : '0;
   end
endmodule // bsc_plc_model

// >>> bench/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
   $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
   import bsc_pkg::*;
   localparam int unsigned DIV  = 2;
   localparam int unsigned HS   = 10;
   localparam int unsigned ADD  = 3;
   localparam int unsigned STRK = 5;
   localparam int unsigned CEIL = 10_000;
   // Rows per code 15..31: {drops on digital and IO-Link, drops on AS-i}
   localparam logic [1:0] DROP [17] = '{2'b00, 2'b11, 2'b00, 2'b00, 2'b11, 2'b11, 2'b11, 2'b11, 2'b10,
                                        2'b10, 2'b10, 2'b10, 2'b10, 2'b00, 2'b10, 2'b10, 2'b11};
   logic             core_clk_i  = 1'b0;
   logic             rst_b_i     = 1'b0;
   bsc_avl_req_t     avl_req     = '0;
   logic [31:0]      avl_rd;
   logic [31:0]      rdata;
   logic             avl_wait;
   bsc_seat_t        seat_req;
   bsc_seat_t        pos_hit;
   bsc_seat_t        sv_on;
   logic             sel_btn     = 1'b0;
   logic             ent_btn     = 1'b0;
   logic             setup_ok    = 1'b1;
   logic             seat_sensor = 1'b1;
   logic             handshake;
   logic             valve_state;
   logic [1:0]       sv_count    = 2'h3;
   bsc_if_t          if_var      = BSC_IF_DIGITAL;
   logic [ERR_W-1:0] errors      = '0;
   int unsigned      fails       = 0;
   int unsigned      n_checks    = 0;
   int unsigned      cycles      = 0;
   int unsigned      sv_len;
   int unsigned      hs_len;
   int unsigned      tail_len;

   always #20 core_clk_i = ~core_clk_i;

   bsc_burst_clean #(.TICK_DIV(DIV), .HS_T(HS), .ADD_T(ADD)) u_dut (
      .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .avl_req_i(avl_req), .avl_readdata_o(avl_rd),
      .avl_waitrequest_o(avl_wait), .seat_req_i(seat_req), .select_btn_i(sel_btn),
      .enter_btn_i(ent_btn), .setup_ok_i(setup_ok), .sv_count_i(sv_count),
      .seat_sensor_i(seat_sensor), .if_variant_i(if_var), .pos_reached_i(pos_hit),
      .errors_i(errors), .sv_on_o(sv_on), .handshake_o(handshake), .valve_state_o(valve_state));

   bsc_plc_model u_plc (.core_clk_i(core_clk_i), .sv_on_i(sv_on), .seat_req_o(seat_req),
                        .pos_reached_o(pos_hit));

   ////////////////////////////////////////////////////////////
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == CEIL) begin
         fails++;
         conclude();
      end
   end

   task automatic done(input string nm);
      $display("test %s ended", nm);
   endtask

   // Request held until the edge that sees waitrequest low
   task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] wd);
      @(posedge core_clk_i);
      avl_req <= '{read: ~wr, write: wr, address: a, writedata: wd};
      do @(posedge core_clk_i); while (avl_wait !== 1'b0);
      rdata = avl_rd;
      avl_req <= '0;
   endtask

   task automatic press(input int unsigned n_sel);
      for (int i = 0; i <= n_sel; i++) begin
         if (i < n_sel) sel_btn <= 1'b1;
         else ent_btn <= 1'b1;
         repeat (5) @(posedge core_clk_i);
         sel_btn <= 1'b0;
         ent_btn <= 1'b0;
         repeat (5) @(posedge core_clk_i);
      end
   endtask

   task automatic seat_run(input logic up, input logic want_hs);
      bsc_seat_t   exp_sv;
      int unsigned lat;
      exp_sv = '{upper: up, lower: ~up};
      lat    = 0;
      sv_len = 0;
      hs_len = 0;
      tail_len = 0;
      fork
         u_plc.pulse(up);
         begin
            while (sv_on === 2'b00) begin @(posedge core_clk_i); lat++; end
            `CHK("sv_select", exp_sv, sv_on)
            `CHK("sv_latency", 1'b1, lat <= 8)
            while (sv_on !== 2'b00) begin @(posedge core_clk_i); sv_len++; end
            `CHK("req_still_high", 1'b1, seat_req != 2'b00)
            while (want_hs && handshake !== 1'b1) begin @(posedge core_clk_i); tail_len++; end
            while (want_hs && handshake === 1'b1) begin @(posedge core_clk_i); hs_len++; end
         end
      join
   endtask

   ////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge core_clk_i);
      `CHK("sv_in_reset", 2'b00, sv_on)
      `CHK("hs_in_reset", 1'b0, handshake)
      `CHK("vs_in_reset", 1'b1, valve_state)
      repeat (8) @(posedge core_clk_i);
      rst_b_i <= 1'b1;
      av(1'b0, REG_CTRL, '0);
      `CHK("ctrl_reset", 32'h0000_0000, rdata)
      av(1'b0, REG_STROKE, '0);
      `CHK("stroke_reset", 32'h0000_0000, rdata)
      av(1'b0, 4'h2, '0);
      `CHK("unmapped", 32'h0000_0000, rdata)
      av(1'b0, REG_STATUS, '0);
      `CHK("status_reset", 32'h0000_00D0, rdata)
      done("reset");
      sv_count <= 2'h1;
      av(1'b1, REG_CTRL, 32'h0000_0001);
      av(1'b0, REG_CTRL, '0);
      `CHK("en_one_sv", 32'h0000_0000, rdata)
      sv_count <= 2'h2;
      setup_ok <= 1'b0;
      av(1'b1, REG_CTRL, 32'h0000_0001);
      av(1'b0, REG_CTRL, '0);
      `CHK("en_no_setup", 32'h0000_0000, rdata)
      setup_ok <= 1'b1;
      av(1'b1, REG_CTRL, 32'h0000_0001);
      av(1'b0, REG_CTRL, '0);
      `CHK("en_param", 32'h0000_0001, rdata)
      av(1'b1, REG_CTRL, 32'h0000_0002);
      av(1'b0, REG_CTRL, '0);
      `CHK("factory_clear", 32'h0000_0000, rdata)
      done("enable");
      press(4);
      av(1'b0, REG_CTRL, '0);
      `CHK("btn_on", 32'h0000_0001, rdata)
      press(3);
      av(1'b0, REG_CTRL, '0);
      `CHK("btn_three", 32'h0000_0001, rdata)
      press(4);
      av(1'b0, REG_CTRL, '0);
      `CHK("btn_off", 32'h0000_0000, rdata)
      done("buttons");
      av(1'b1, REG_CTRL, 32'h0000_0001);
      for (int r = 0; r < 2; r++) begin
         seat_run(r == 0, 1'b1);
         `CHK("sv_len", 1'b1, sv_len <= u_plc.reach_dly + 8)
         `CHK("hs_len", 1'b1, hs_len >= HS * DIV)
         `CHK("hs_gap", 0, tail_len)
      end
      done("pulses");
      // Timing path: no lift sensor and a stem that never reports arrival
      seat_sensor <= 1'b0;
      u_plc.reach_en = 1'b0;
      av(1'b1, REG_STROKE, 32'(STRK));
      av(1'b0, REG_STROKE, '0);
      `CHK("stroke_rw", 32'(STRK), rdata)
      seat_run(1'b0, 1'b1);
      // Valve drops once the stroke time is over; the margin runs after release
      `CHK("stroke_end", 1'b1, sv_len + 2 >= (STRK + 1) * DIV && sv_len <= (STRK + 1) * DIV + 2)
      `CHK("tail_len", 1'b1, tail_len + 1 >= ADD * DIV && tail_len <= ADD * DIV + 1)
      `CHK("hs_len_timed", 1'b1, hs_len >= HS * DIV)
      done("stroke");
      for (int v = 0; v < 3; v++) begin
         if_var <= bsc_if_t'(v);
         for (int c = 0; c < 17; c++) begin
            errors <= 17'h0_0001 << c;
            repeat (6) @(posedge core_clk_i);
            `CHK("valve_state", ~DROP[c][v != 1], valve_state)
            errors <= '0;
            repeat (6) @(posedge core_clk_i);
            `CHK("valve_ok", 1'b1, valve_state)
         end
      end
      errors <= 17'h0_0020;
      // Let the two synchroniser stages settle before the register is read
      repeat (4) @(posedge core_clk_i);
      av(1'b0, REG_ERRORS, '0);
      `CHK("err_reg", 32'h0000_0020, rdata)
      done("valve_state");
      rst_b_i <= 1'b0;
      repeat (3) @(posedge core_clk_i);
      rst_b_i <= 1'b1;
      av(1'b0, REG_CTRL, '0);
      `CHK("ctrl_rereset", 32'h0000_0000, rdata)
      done("rereset");
      conclude();
   end
endmodule // tb_top
